// ### ebr_fab.sv
`default_nettype none
module ebr_fab (
  input  wire logic             clk_i,
  output var ebr_pkg::ebr_req_s req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import ebr_pkg::*;

  // idle: no operation, all lanes on, address hold off
  initial req_o = '{addr: '0, din: '0, wren: 1'b0, rden: 1'b0, byteen: 4'hf,
                    ce_in: 1'b1, ce_out: 1'b1, addr_hold: 1'b0};

  // one request for one clock, then release; write data is flipped so a late
  // sample cannot match by luck
  task automatic put(input ebr_req_s r);
    req_o <= r;
    @(posedge clk_i);
    req_o.din       <= ~r.din;
    req_o.wren      <= 1'b0;
    req_o.rden      <= 1'b0;
    req_o.byteen    <= 4'hf;
    req_o.ce_in     <= 1'b1;
    req_o.ce_out    <= 1'b1;
    req_o.addr_hold <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### ebr_pkg.sv
`default_nettype none
package ebr_pkg;
  // ---------------------------------------------------------------
  // array geometry
  // ---------------------------------------------------------------
  localparam int unsigned EBR_BYTES = 1024; // nine-bit lanes
  localparam int unsigned EBR_IW    = 10;   // lane index width
  localparam int unsigned EBR_LW    = 9;    // stored bits per lane
  localparam int unsigned EBR_NL    = 4;    // lanes per port access
  localparam int unsigned EBR_AW    = 13;   // widest port address
  localparam int unsigned EBR_DW    = 36;   // widest port data

  // ---------------------------------------------------------------
  // port shapes and block modes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    EBR_W1  = 4'h0, EBR_W2  = 4'h1, EBR_W4  = 4'h2,
    EBR_W8  = 4'h3, EBR_W9  = 4'h4, EBR_W16 = 4'h5,
    EBR_W18 = 4'h6, EBR_W32 = 4'h7, EBR_W36 = 4'h8
  } ebr_width_e;

  typedef enum logic [1:0] {
    EBR_SINGLE = 2'h0, EBR_DUAL = 2'h1, EBR_PACKED = 2'h2
  } ebr_mode_e;

  // ---------------------------------------------------------------
  // register map (byte offsets) and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] EBR_CTRL_OFS   = 8'h00;
  localparam logic [7:0] EBR_WIDTH_OFS  = 8'h04;
  localparam logic [7:0] EBR_STATUS_OFS = 8'h08;
  localparam logic [7:0] EBR_LDADR_OFS  = 8'h0c;
  localparam logic [7:0] EBR_LDDAT_OFS  = 8'h10;
  localparam int unsigned EBR_CTRL_W    = 7;
  localparam int unsigned EBR_RUN_BIT   = 0;
  localparam int unsigned EBR_MODE_LSB  = 1;
  localparam int unsigned EBR_OREGA_BIT = 3;
  localparam int unsigned EBR_OREGB_BIT = 4;
  localparam int unsigned EBR_NEWA_BIT  = 5;
  localparam int unsigned EBR_NEWB_BIT  = 6;
  localparam int unsigned EBR_WB_LSB    = 4;
  localparam logic [6:0]  EBR_CTRL_RST  = 7'h00;
  localparam logic [3:0]  EBR_WIDTH_RST = 4'h8;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [EBR_AW-1:0] addr;
    logic [EBR_DW-1:0] din;
    logic              wren;
    logic              rden;
    logic [3:0]        byteen;
    logic              ce_in;
    logic              ce_out;
    logic              addr_hold;
  } ebr_req_s;

  typedef struct packed {
    ebr_width_e width;
    logic       out_reg;
    logic       rdw_new;
    logic       packed_en;
    logic       upper;
    logic       wr_allow;
  } ebr_pcfg_s;

  typedef struct packed {
    logic [EBR_NL-1:0][EBR_IW-1:0] idx;
    logic [EBR_NL-1:0][EBR_LW-1:0] mask;
    logic [EBR_NL-1:0][EBR_LW-1:0] wdat;
  } ebr_lanes_s;
endpackage
`default_nettype wire

// ### ebr_port.sv
`default_nettype none
module ebr_port (
  input  wire logic                               clk_i,
  input  wire logic                               rstn_i,
  input  wire logic                               aclr_i,
  input  wire ebr_pkg::ebr_pcfg_s                 cfg_i,
  input  wire ebr_pkg::ebr_req_s                  req_i,
  input  wire logic [ebr_pkg::EBR_NL-1:0][8:0]    rd_i,
  output ebr_pkg::ebr_lanes_s                     lanes_o,
  output logic [ebr_pkg::EBR_DW-1:0]              q_o
);
  import ebr_pkg::*;

  logic [EBR_AW-1:0] addr_reg;
  logic [EBR_DW-1:0] din_reg;
  logic              we_reg;
  logic              re_reg;
  logic [3:0]        be_reg;
  logic [EBR_DW-1:0] latch_reg;
  logic [EBR_DW-1:0] q_reg;
  logic [EBR_DW-1:0] view;
  logic [9:0]        base;
  logic [2:0]        sh;
  logic [8:0]        smask;
  logic [2:0]        nl;
  logic [3:0]        be_eff;

  // ---------------------------------------------------------------
  // input stage
  // ---------------------------------------------------------------
  // address register: the only input register with a user clear
  always_ff @(posedge clk_i or negedge rstn_i or posedge aclr_i) begin
    if (!rstn_i) begin
      addr_reg <= '0;
    end else if (aclr_i) begin
      addr_reg <= '0; // RULE13
    end else if (req_i.ce_in && !req_i.addr_hold) begin // RULE4 RULE18
      addr_reg <= req_i.addr;
    end
  end

  // strobes: chip reset only, no user clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      we_reg <= 1'b0;
      re_reg <= 1'b0;
    end else if (req_i.ce_in) begin // RULE4
      we_reg <= req_i.wren; // RULE3
      re_reg <= req_i.rden; // RULE3
    end
  end

  // data and lane-mask registers carry no clear at all
  always_ff @(posedge clk_i) begin
    if (req_i.ce_in) begin
      din_reg <= req_i.din;
      be_reg  <= req_i.byteen; // RULE8
    end
  end

  // ---------------------------------------------------------------
  // shape decode
  // ---------------------------------------------------------------
  // narrow shapes pick bits inside one lane; wide shapes span lanes
  always_comb begin
    base  = addr_reg[9:0];
    sh    = 3'h0;
    smask = 9'h0ff;
    nl    = 3'h1;
    case (cfg_i.width) // RULE2
      EBR_W1:  begin base = addr_reg[12:3]; sh = addr_reg[2:0]; smask = 9'h001; end
      EBR_W2:  begin base = addr_reg[11:2]; sh = {addr_reg[1:0], 1'b0}; smask = 9'h003; end
      EBR_W4:  begin base = addr_reg[10:1]; sh = {addr_reg[0], 2'b00}; smask = 9'h00f; end
      EBR_W8:  begin base = addr_reg[9:0]; end
      EBR_W9:  begin base = addr_reg[9:0]; smask = 9'h1ff; end
      EBR_W16: begin base = {addr_reg[8:0], 1'b0}; nl = 3'h2; end
      EBR_W18: begin base = {addr_reg[8:0], 1'b0}; nl = 3'h2; smask = 9'h1ff; end
      EBR_W32: begin base = {addr_reg[7:0], 2'b00}; nl = 3'h4; end
      EBR_W36: begin base = {addr_reg[7:0], 2'b00}; nl = 3'h4; smask = 9'h1ff; end
      default: begin base = addr_reg[12:3]; smask = 9'h001; end
    endcase
    // masking exists only on the multi-lane shapes
    be_eff = (nl == 3'h1) ? 4'hf : be_reg; // RULE9
  end

  // ---------------------------------------------------------------
  // lane build and read view
  // ---------------------------------------------------------------
  always_comb begin
    logic [8:0] m;
    logic [8:0] src;
    logic [8:0] wd;
    logic [8:0] mrg;
    logic [8:0] v;
    logic       wr;
    m = '0; src = '0; wd = '0; mrg = '0; v = '0; wr = 1'b0;
    view    = '0;
    lanes_o = '0;
    for (int k = 0; k < EBR_NL; k++) begin
      lanes_o.idx[k] = base | 10'(k);
      if (cfg_i.packed_en) begin
        lanes_o.idx[k] = {cfg_i.upper, lanes_o.idx[k][8:0]}; // RULE12
      end
      if (3'(k) < nl) begin
        m   = 9'(smask << sh);
        // ninth bit rides along as plain data, never computed
        src = smask[8] ? din_reg[9*k +: 9] : {1'b0, din_reg[8*k +: 8]}; // RULE6
        wd  = 9'(src << sh) & m;
        wr  = we_reg && be_eff[k] && cfg_i.wr_allow && req_i.ce_in; // RULE7 RULE10
        lanes_o.mask[k] = wr ? m : 9'h000;
        lanes_o.wdat[k] = wr ? wd : 9'h000;
        // unwritten lanes always show old data
        mrg = (wr && cfg_i.rdw_new) ? ((rd_i[k] & ~m) | wd) : rd_i[k]; // RULE11 RULE15
        v   = 9'(mrg >> sh) & smask;
        if (smask[8]) begin
          view[9*k +: 9] = v;
        end else begin
          view[8*k +: 8] = v[7:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // output latch and output register
  // ---------------------------------------------------------------
  // latch holds across writes with read enable low
  always_ff @(posedge clk_i or negedge rstn_i or posedge aclr_i) begin
    if (!rstn_i) begin
      latch_reg <= '0; // RULE21
    end else if (aclr_i) begin
      latch_reg <= '0; // RULE13
    end else if (req_i.ce_in && re_reg) begin // RULE14 RULE20
      latch_reg <= view;
    end
  end

  // the registered option adds one stage behind the latch
  always_ff @(posedge clk_i or negedge rstn_i or posedge aclr_i) begin
    if (!rstn_i) begin
      q_reg <= '0; // RULE21
    end else if (aclr_i) begin
      q_reg <= '0; // RULE13
    end else if (cfg_i.out_reg) begin
      if (req_i.ce_out) begin // RULE4 RULE5
        q_reg <= latch_reg; // RULE19
      end
    end else if (req_i.ce_in && re_reg) begin // RULE20
      q_reg <= view;
    end
  end

  assign q_o = q_reg;
endmodule
`default_nettype wire

// ### ebr_top.sv
`default_nettype none
// Overview of operation
// [RULE1] array holds 8192 data bits, 9216 counting the ninth bit per byte
// [RULE2] port shapes 8192x1 through 256x36, nine shapes selectable per port
// [RULE3] separate read and write enables per port, either may stay low
// [RULE4] clock enable low freezes input registers, output registers and array
// [RULE5] each port has an input-side and an output-side clock enable
// [RULE6] ninth bit per byte stored and returned as data, no parity made
// [RULE7] lanes with mask low keep their previously written value
// [RULE8] lane mask defaults all ones and its register has no clear
// [RULE9] lane masking applies only to 16, 18, 32 and 36 bit writes
// [RULE10] mask active high, bit 0 lowest lane, any combination allowed
// [RULE11] masked lane reads old data, enabled lane old or new by config
// [RULE12] packed mode gives two half-size single ports, at most 18 bits
// [RULE13] user clear reaches only read address, output latch, output reg
// [RULE14] reads and writes act on the rising clock edge
// [RULE15] same-port collision old or new, other port sees old data
// [RULE16] dual-port allows any read/write mix, but not 32 or 36 wide
// [RULE17] contents loadable before operation starts
// [RULE18] address hold keeps the address register, one per port, default low
// [RULE19] registered outputs deliver data one clock later
// [RULE20] outputs keep last read value while read enable is low
// [RULE21] data outputs read zero after reset until the first read
module ebr_top (
  input  wire logic                      mclk_i,
  input  wire logic                      resetn_i,
  input  wire logic                      hsel_i,
  input  wire logic [31:0]               haddr_i,
  input  wire logic [1:0]                htrans_i,
  input  wire logic                      hwrite_i,
  input  wire logic [2:0]                hsize_i,
  input  wire logic [31:0]               hwdata_i,
  input  wire logic                      hready_i,
  output logic [31:0]                    hrdata_o,
  output logic                           hreadyout_o,
  output logic                           hresp_o,
  input  wire ebr_pkg::ebr_req_s         req_a_i,
  input  wire logic                      aclr_a_i,
  input  wire ebr_pkg::ebr_req_s         req_b_i,
  input  wire logic                      aclr_b_i,
  output logic [ebr_pkg::EBR_DW-1:0]     q_a_o,
  output logic [ebr_pkg::EBR_DW-1:0]     q_b_o
);
  import ebr_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  // storage lanes; contents survive reset
  logic [EBR_LW-1:0]        mem_q [EBR_BYTES];

  // software registers
  logic [EBR_CTRL_W-1:0]    ctrl_reg;
  logic [3:0]               wid_a_reg;
  logic [3:0]               wid_b_reg;
  logic [EBR_IW-1:0]        ld_adr_reg;

  // bus slave state
  logic                     wr_pend_reg;
  logic                     rd_pend_reg;
  logic [7:0]               ofs_reg;
  logic [31:0]              hrdata_reg;
  logic                     hready_reg;

  // decode and port setup
  logic [31:0]              rdata_next;
  logic                     ahb_go;
  logic                     ld_we;
  logic                     run;
  ebr_mode_e                mode;
  logic                     cfg_err;
  ebr_pcfg_s                pcfg_a;
  ebr_pcfg_s                pcfg_b;

  // lane traffic to the array
  ebr_lanes_s               lanes_a;
  ebr_lanes_s               lanes_b;
  logic [EBR_NL-1:0][8:0]   rd_a;
  logic [EBR_NL-1:0][8:0]   rd_b;

  // register map, byte offsets:
  //   0x00 control
  //     [0]   run; preload shut
  //     [2:1] mode
  //     [3]   port a out reg
  //     [4]   port b out reg
  //     [5]   port a new data
  //     [6]   port b new data
  //   0x04 shapes
  //     [3:0] port a
  //     [7:4] port b
  //   0x08 status, read only
  //     [0]   bad setup
  //     [1]   run
  //   0x0c preload pointer
  //   0x10 preload data
  //     pointer steps per write
  //     refused while running

  // ---------------------------------------------------------------
  // bus slave phases
  // ---------------------------------------------------------------
  // a transfer is taken only while the bus is ready
  assign ahb_go = hsel_i && htrans_i[1] && hready_i;

  // reads cost one wait so the data flop sees settled state
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      ofs_reg     <= 8'h00;
      hready_reg  <= 1'b1;
    end else begin
      wr_pend_reg <= ahb_go && hwrite_i;
      rd_pend_reg <= ahb_go && !hwrite_i;
      hready_reg  <= !(ahb_go && !hwrite_i);
      if (ahb_go) begin
        ofs_reg <= haddr_i[7:0];
      end
    end
  end

  // unmapped offsets read zero, only OKAY is ever answered
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (ofs_reg)
      EBR_CTRL_OFS:   rdata_next = 32'(ctrl_reg);
      EBR_WIDTH_OFS:  rdata_next = 32'({wid_b_reg, wid_a_reg});
      EBR_STATUS_OFS: rdata_next = 32'({run, cfg_err});
      EBR_LDADR_OFS:  rdata_next = 32'(ld_adr_reg);
      EBR_LDDAT_OFS:  rdata_next = 32'(mem_q[ld_adr_reg]);
      default:        rdata_next = 32'h0000_0000;
    endcase
  end

  // read data and response flops
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_pend_reg) begin
      hrdata_reg <= rdata_next;
    end
  end

  assign hrdata_o    = hrdata_reg;
  assign hreadyout_o = hready_reg;
  assign hresp_o     = 1'b0;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // control: run, mode, output register and collision options
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_reg <= EBR_CTRL_RST;
    end else if (wr_pend_reg && ofs_reg == EBR_CTRL_OFS) begin
      ctrl_reg <= hwdata_i[EBR_CTRL_W-1:0];
    end
  end

  // port shapes, one nibble per port
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wid_a_reg <= EBR_WIDTH_RST;
      wid_b_reg <= EBR_WIDTH_RST;
    end else if (wr_pend_reg && ofs_reg == EBR_WIDTH_OFS) begin
      wid_a_reg <= hwdata_i[3:0]; // RULE2
      wid_b_reg <= hwdata_i[EBR_WB_LSB +: 4];
    end
  end

  // ---------------------------------------------------------------
  // preload path
  // ---------------------------------------------------------------
  // preload is refused once the ports run, so it never races them
  assign ld_we = wr_pend_reg && ofs_reg == EBR_LDDAT_OFS && !run; // RULE17

  // load pointer steps after each accepted data word
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ld_adr_reg <= '0;
    end else if (wr_pend_reg && ofs_reg == EBR_LDADR_OFS) begin
      ld_adr_reg <= hwdata_i[EBR_IW-1:0];
    end else if (ld_we) begin
      ld_adr_reg <= ld_adr_reg + 10'h001;
    end
  end

  // ---------------------------------------------------------------
  // mode checks and port configuration
  // ---------------------------------------------------------------
  assign run  = ctrl_reg[EBR_RUN_BIT];
  assign mode = ebr_mode_e'(ctrl_reg[EBR_MODE_LSB +: 2]);

  // an illegal shape or mode blocks every port write
  always_comb begin
    cfg_err = (wid_a_reg > EBR_W36) || (wid_b_reg > EBR_W36) ||
              (mode > EBR_PACKED);
    if (mode == EBR_DUAL) begin
      cfg_err = cfg_err || (wid_a_reg >= EBR_W32) || (wid_b_reg >= EBR_W32); // RULE16
    end
    if (mode == EBR_PACKED) begin
      cfg_err = cfg_err || (wid_a_reg > EBR_W18) || (wid_b_reg > EBR_W18); // RULE12
    end
  end

  // port a writes whenever the block runs with a legal setup
  always_comb begin
    pcfg_a.width     = ebr_width_e'(wid_a_reg);
    pcfg_a.out_reg   = ctrl_reg[EBR_OREGA_BIT]; // RULE19
    pcfg_a.rdw_new   = ctrl_reg[EBR_NEWA_BIT];
    pcfg_a.packed_en = (mode == EBR_PACKED);
    pcfg_a.upper     = 1'b0;
    pcfg_a.wr_allow  = run && !cfg_err;
  end

  // port b may only write when the block is shared
  always_comb begin
    pcfg_b.width     = ebr_width_e'(wid_b_reg);
    pcfg_b.out_reg   = ctrl_reg[EBR_OREGB_BIT];
    pcfg_b.rdw_new   = ctrl_reg[EBR_NEWB_BIT];
    pcfg_b.packed_en = (mode == EBR_PACKED);
    pcfg_b.upper     = 1'b1; // RULE12
    pcfg_b.wr_allow  = run && !cfg_err && (mode != EBR_SINGLE);
  end

  // ---------------------------------------------------------------
  // storage array
  // ---------------------------------------------------------------
  // both ports read the pre-edge value, so cross-port reads are old
  always_comb begin
    for (int k = 0; k < EBR_NL; k++) begin
      rd_a[k] = mem_q[lanes_a.idx[k]]; // RULE15
      rd_b[k] = mem_q[lanes_b.idx[k]];
    end
  end

  // one array, 1024 lanes of nine bits; port b wins a same-lane clash
  always_ff @(posedge mclk_i) begin
    if (ld_we) begin
      mem_q[ld_adr_reg] <= hwdata_i[EBR_LW-1:0]; // RULE17
    end
    for (int k = 0; k < EBR_NL; k++) begin
      if (|lanes_a.mask[k]) begin // RULE14
        mem_q[lanes_a.idx[k]] <= (rd_a[k] & ~lanes_a.mask[k]) | lanes_a.wdat[k]; // RULE1 RULE7
      end
    end
    for (int k = 0; k < EBR_NL; k++) begin
      if (|lanes_b.mask[k]) begin
        mem_q[lanes_b.idx[k]] <= (rd_b[k] & ~lanes_b.mask[k]) | lanes_b.wdat[k];
      end
    end
  end

  // ---------------------------------------------------------------
  // port engines
  // ---------------------------------------------------------------
  // port a
  ebr_port u_port_a (
    .clk_i   (mclk_i),
    .rstn_i  (resetn_i),
    .aclr_i  (aclr_a_i),
    .cfg_i   (pcfg_a),
    .req_i   (req_a_i),
    .rd_i    (rd_a),
    .lanes_o (lanes_a),
    .q_o     (q_a_o)
  );

  // port b
  ebr_port u_port_b (
    .clk_i   (mclk_i),
    .rstn_i  (resetn_i),
    .aclr_i  (aclr_b_i),
    .cfg_i   (pcfg_b),
    .req_i   (req_b_i),
    .rd_i    (rd_b),
    .lanes_o (lanes_b),
    .q_o     (q_b_o)
  );
endmodule
`default_nettype wire

// ### ebr_top_properties.sv
`default_nettype none
module ebr_top_checker (
  input wire logic              mclk_i,
  input wire logic              resetn_i,
  input wire logic              hsel_i,
  input wire logic [31:0]       haddr_i,
  input wire logic [1:0]        htrans_i,
  input wire logic              hwrite_i,
  input wire logic              hready_i,
  input wire logic [31:0]       hrdata_o,
  input wire logic              hreadyout_o,
  input wire logic              hresp_o,
  input wire ebr_pkg::ebr_req_s req_a_i,
  input wire logic              aclr_a_i,
  input wire logic              aclr_b_i,
  input wire logic [35:0]       q_a_o,
  input wire logic [35:0]       q_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import ebr_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  // ---------------------------------------------------------------
  // bus transfer steps
  // ---------------------------------------------------------------
  sequence rd_take;
    hsel_i && htrans_i[1] && hready_i && !hwrite_i;
  endsequence
  sequence wr_take;
    hsel_i && htrans_i[1] && hready_i && hwrite_i;
  endsequence
  // one wait cycle, then ready with the data
  sequence wait_one;
    !hreadyout_o ##1 hreadyout_o;
  endsequence

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_resp_okay: assert property (hresp_o == 1'b0)
    else $error("error response seen");
  a_read_wait: assert property (rd_take |=> wait_one)
    else $error("read data phase is not two cycles");
  a_write_nowait: assert property (wr_take |=> hreadyout_o)
    else $error("write data phase stretched");
  a_unmapped_zero: assert property (rd_take ##0 (haddr_i[7:0] > 8'h13) |-> ##2 hrdata_o == '0)
    else $error("unmapped offset returned data");
  // read data may only move as a read wait ends
  a_rdata_stands: assert property ($changed(hrdata_o) |-> $past(hreadyout_o) == 1'b0)
    else $error("read data moved outside a read");
  a_reset_quiet: assert property ($rose(resetn_i) |-> q_a_o == '0 && q_b_o == '0)
    else $error("data outputs not zero after reset");
  a_clear_zero: assert property ((aclr_a_i |-> q_a_o == '0)
    and (aclr_b_i |-> q_b_o == '0)) else $error("clear did not zero the output");
  // both enables low: the edge must pass unseen
  a_freeze_q: assert property (!req_a_i.ce_in && !req_a_i.ce_out && !aclr_a_i
    |=> aclr_a_i || $stable(q_a_o)) else $error("output moved with clocks disabled");
  // four idle edges flush any pending read, so the output must then sit still
  a_no_read_hold: assert property ((!req_a_i.rden && req_a_i.ce_in
    && req_a_i.ce_out && !aclr_a_i)[*4] |-> $stable(q_a_o)) else $error("output moved");
endmodule

bind ebr_top ebr_top_checker ebr_top_checker_inst (
  .mclk_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o,
  .hreadyout_o, .hresp_o, .req_a_i, .aclr_a_i, .aclr_b_i, .q_a_o, .q_b_o);
`default_nettype wire

// ### tb_embedded_block_ram.sv
`default_nettype none
module tb_embedded_block_ram;
  timeunit 1ns;
  timeprecision 1ps;
  import ebr_pkg::*;

  `define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("BAD %0t got %h exp %h", $time, (got), (exp)); end end

  logic              mclk_i, resetn_i, hsel_i, hwrite_i, aclr_a_i, aclr_b_i;
  logic [31:0]       haddr_i, hwdata_i, hrdata_o, lfsr;
  logic [1:0]        htrans_i;
  logic [2:0]        hsize_i;
  logic              hreadyout_o, hresp_o, newd, oreg, x9;
  logic [EBR_DW-1:0] q_a_o, q_b_o, eq;
  logic [12:0]       ma;
  logic [8:0]        mem [1024];
  ebr_req_s          req_a_i, req_b_i;
  int                fail_count, cmp_count;

  ebr_fab fab_a (.clk_i(mclk_i), .req_o(req_a_i));
  ebr_fab fab_b (.clk_i(mclk_i), .req_o(req_b_i));
  ebr_top ebr_top_inst (
    .mclk_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
    .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .req_a_i, .aclr_a_i,
    .req_b_i, .aclr_b_i, .q_a_o, .q_b_o);

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic summarize();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one single transfer; waits as long as the slave asks, the watchdog ends a hang
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel_i   <= 1'b1;
    haddr_i  <= {24'h0, a};
    htrans_i <= 2'h2;
    hwrite_i <= w;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    `CHK(r, e)
  endtask

  task automatic cfg(input logic [31:0] c);
    wr(EBR_CTRL_OFS, c);
    newd = c[EBR_NEWA_BIT];
    oreg = c[EBR_OREGA_BIT];
  endtask

  // port a access: model first, then drive, then compare once settled
  task automatic mop(input logic [12:0] a, input logic [35:0] d, input logic [3:0] be,
                     input logic w, input logic rdn, input logic ce, input logic hold);
    ebr_req_s    r;
    logic [8:0]  old;
    logic [9:0]  li;
    logic [35:0] prev;
    logic        en;
    r = '{addr: a, din: d, wren: w, rden: rdn, byteen: be, ce_in: ce, ce_out: ce,
          addr_hold: hold};
    prev = eq;
    if (ce && !hold) ma = a;
    for (int k = 0; k < (x9 ? 1 : 4); k++) begin
      li  = x9 ? ma[9:0] : {ma[7:0], 2'(k)};
      old = mem[li];
      en  = ce && w && (x9 || be[k]);
      if (en) mem[li] = d[9*k +: 9];
      if (ce && rdn) eq[9*k +: 9] = (en && newd) ? mem[li] : old;
    end
    if (ce && rdn && x9) eq[35:9] = '0;
    // idle edges after the request reload the address register
    ma = a;
    fab_a.put(r);
    @(posedge mclk_i);
    if (oreg) begin
      @(negedge mclk_i);
      `CHK(q_a_o, prev)
      @(posedge mclk_i);
    end
    @(negedge mclk_i);
    `CHK(q_a_o, eq)
    @(posedge mclk_i);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] v;
    logic [35:0] eb;
    ebr_req_s    rb;
    lfsr = 32'h99a8;
    {resetn_i, hsel_i, hwrite_i, aclr_a_i, aclr_b_i, htrans_i, haddr_i, hwdata_i} = '0;
    hsize_i = 3'h2;
    {newd, oreg, x9, eq, ma} = '0;
    repeat (4) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(negedge mclk_i);
    `CHK(q_a_o, eq)
    `CHK(q_b_o, eq)
    @(posedge mclk_i);
    rd(EBR_CTRL_OFS, 32'h0);
    rd(EBR_WIDTH_OFS, 32'h88);
    rd(8'h40, 32'h0);
    // preload every lane while stopped, so every later read has a known value
    wr(EBR_LDADR_OFS, 32'h0);
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 9'(rnd());
      wr(EBR_LDDAT_OFS, {23'h0, mem[i]});
    end
    rd(EBR_LDADR_OFS, 32'h0);
    cfg(32'h21);
    // preload is shut while running: pointer and lane must not move
    wr(EBR_LDDAT_OFS, {23'h0, ~mem[0]});
    rd(EBR_LDADR_OFS, 32'h0);
    rd(EBR_LDDAT_OFS, {23'h0, mem[0]});
    rd(EBR_STATUS_OFS, 32'h2);
    for (int i = 0; i < 300; i++) begin
      if (i == 100) cfg(32'h01); // collisions show old data
      if (i == 150) cfg(32'h09); // registered output
      if (i == 200) begin
        cfg(32'h21);
        wr(EBR_WIDTH_OFS, 32'h84); // nine bits wide: lane mask has no say
        x9 = 1'b1;
      end
      v = rnd();
      mop(v[12:0], 36'({rnd(), rnd()}), v[19:16], v[13], |v[15:14], |v[22:20], &v[25:23]);
    end
    // port b may read but never write while the block is single-ported
    rb = '{addr: {5'h0, ma[7:0]}, din: '1, wren: 1'b1, rden: 1'b1, byteen: 4'hf, ce_in: 1'b1,
           ce_out: 1'b1, addr_hold: 1'b0};
    for (int k = 0; k < 4; k++) eb[9*k +: 9] = mem[{ma[7:0], 2'(k)}];
    repeat (2) begin
      fab_b.put(rb);
      @(posedge mclk_i);
      @(negedge mclk_i);
      `CHK(q_b_o, eb)
      @(posedge mclk_i);
    end
    {aclr_a_i, aclr_b_i} <= 2'b11;
    @(negedge mclk_i);
    `CHK(q_a_o, 36'h0)
    `CHK(q_b_o, 36'h0)
    eq = '0;
    @(posedge mclk_i);
    {aclr_a_i, aclr_b_i} <= 2'b00;
    @(posedge mclk_i);
    mop(ma, 36'h0, 4'h0, 1'b0, 1'b1, 1'b1, 1'b0);
    summarize();
  end

  // run needs about 3000 cycles; this cuts a hang well beyond that
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
